// file: rtl/cgs_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1 - Overload bit 6 high while own overload frame is sent.
// RULE2 - Transmit-busy bit 4 high during any sent frame, ack, pending space.
// RULE3 - Receive-busy bit 3 high while receiver acquires or monitors a frame.
// RULE4 - Bit 2 shows actual enabled state after delayed enable or disable.
// RULE5 - Status bits 6, 4, 3, 2 raise no interrupt; polling only.
// RULE6 - Bits 7 and 5 reserved; software never writes ones there.
// RULE7 - Global status at address AAh is read-only.
// RULE8 - Software writes 02h to general control before object setup.
// RULE9 - Page upper nibble selects object; later object accesses use it.
// RULE10 - Standard id bits 10..3 in byte 1, bits 2..0 top of byte 2.
// RULE11 - Mask byte FFh makes every matching id bit compared.
// RULE12 - Control write 88h arms object as receiver, length eight.
// RULE13 - Control write 18h launches the prepared transmission.
// RULE14 - Eight payload bytes go as eight writes to message data.
// RULE15 - Object interrupt enables, one bit per object over two registers.
// RULE16 - Software clears object status, and control for receive, first.
// RULE17 - Receive interrupts need global, CAN enables and 20h write.
// RULE18 - Message byte pointer increments per access, wrapping in eight; a write refused by a full buffer leaves it unchanged.
// RULE19 - Object enabled bit clears when its transfer completes.
// RULE20 - Config field: 00 off, 01 transmit, 10 receive, 11 buffer.
// RULE21 - Global status bits registered on the system clock.
module cgs_top
    import cgs_pkg::*;
#(
    parameter int ENA_DELAY = ENA_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic msg_wr_ready,
    input wire logic eng_ovl_own,
    input wire logic eng_tx_frame,
    input wire logic eng_tx_ack,
    input wire logic eng_ifs,
    input wire logic eng_tx_pending,
    input wire logic eng_rx_active,
    input wire logic eng_bus_off,
    input wire logic eng_err_passive,
    input wire logic eng_done,
    input wire logic [3:0] eng_done_obj,
    input wire logic [10:0] eng_rx_id,
    output logic can_enable,
    output logic [14:0] obj_armed,
    output logic tx_launch,
    output logic [3:0] tx_launch_obj,
    output logic id_accept,
    output logic msg_valid,
    input wire logic msg_ready,
    output logic [3:0] msg_obj,
    output logic [2:0] msg_ptr,
    output logic [7:0] msg_byte
);

    typedef struct packed {
        logic [7:0] gcon;
        logic [7:0] gie;
        logic [7:0] page;
        logic [14:0][7:0] ctrl;
        logic [14:0][7:0] stat;
        logic [7:0] ie1;
        logic [7:0] ie2;
        logic [3:0][7:0] idt;
        logic [3:0][7:0] idm;
        logic [14:0] armed;
        logic [7:0] gsta;
        cgs_en_t en_st;
        logic [15:0] en_cnt;
        logic [7:0] rdata;
        logic launch;
        logic [3:0] launch_obj;
        logic accept;
    } cgs_st_t;

    cgs_st_t st_q;
    cgs_st_t st_d;
    logic [3:0] sel;
    logic sel_ok;
    logic msg_hit;
    logic [10:0] std_id;
    logic [10:0] std_mask;

    cgs_fifo_if #(.W(FIFO_W)) fq ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] page_obj(input logic [7:0] p);
        return p[PG_OBJ_LSB +: 4]; // RULE9
    endfunction : page_obj

    // Transmit request bit with a cleared field still means transmit
    function automatic cgs_cfg_t cfg_of(input logic [7:0] c);
        cgs_cfg_t r;
        r = cgs_cfg_t'(c[CT_CFG_LSB +: 2]); // RULE20
        if (r == CFG_DIS && c[CT_TXREQ]) begin
            r = CFG_TX; // RULE13
        end
        return r;
    endfunction : cfg_of

    assign sel = page_obj(st_q.page);
    assign sel_ok = (sel < 4'(NUM_OBJ));
    assign msg_hit = (sfr_addr == A_MSG) && (sfr_wr || sfr_rd);
    assign std_id = {st_q.idt[0], st_q.idt[1][7:5]}; // RULE10
    assign std_mask = {st_q.idm[0], st_q.idm[1][7:5]};

    // ------------------------------------------------------------
    // Message data path
    // ------------------------------------------------------------
    // Full buffer refuses the byte; host must poll msg_wr_ready
    assign fq.in_valid = sfr_wr && (sfr_addr == A_MSG) && sel_ok; // RULE14
    assign fq.in_data = {sel, st_q.page[PTR_W-1:0], sfr_wdata};
    assign fq.out_ready = msg_ready;
    assign msg_wr_ready = fq.in_ready;
    assign msg_valid = fq.out_valid;
    assign {msg_obj, msg_ptr, msg_byte} = fq.out_data;

    cgs_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .f(fq)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic idle;
        logic req;
        idle = !(eng_tx_frame || eng_tx_ack || eng_rx_active);
        req = st_q.gcon[GC_ENA];
        st_d = st_q;
        st_d.launch = 1'b0;

        // Completion first, so a re-arm write in the same cycle wins
        if (eng_done && eng_done_obj < 4'(NUM_OBJ)) begin
            st_d.armed[eng_done_obj] = 1'b0; // RULE19
        end

        if (sfr_wr) begin
            case (sfr_addr)
                A_GCON: st_d.gcon = sfr_wdata;
                A_GIE: st_d.gie = sfr_wdata; // RULE17
                A_PAGE: st_d.page = sfr_wdata; // RULE9
                A_IE1: st_d.ie1 = sfr_wdata; // RULE15
                A_IE2: st_d.ie2 = sfr_wdata; // RULE15
                A_STCH: begin
                    if (sel_ok) begin
                        st_d.stat[sel] = sfr_wdata;
                    end
                end
                A_CONCH: begin
                    if (sel_ok) begin
                        st_d.ctrl[sel] = sfr_wdata; // RULE12
                        st_d.armed[sel] = (cfg_of(sfr_wdata) != CFG_DIS);
                        if (cfg_of(sfr_wdata) == CFG_TX) begin
                            st_d.launch = 1'b1; // RULE13
                            st_d.launch_obj = sel;
                        end
                    end
                end
                default: begin
                    // Global status ignores writes
                    for (int i = 0; i < 4; i++) begin
                        if (sfr_addr == A_IDT1 + 8'(i)) begin
                            st_d.idt[i] = sfr_wdata; // RULE10
                        end
                        if (sfr_addr == A_IDM1 + 8'(i)) begin
                            st_d.idm[i] = sfr_wdata; // RULE11
                        end
                    end
                end
            endcase
        end

        // Refused buffer write leaves the pointer where it was
        if (msg_hit && (sfr_rd || fq.in_ready)) begin
            st_d.page[PTR_W-1:0] = st_q.page[PTR_W-1:0] + 3'h1; // RULE18
        end

        case (sfr_addr)
            A_GSTA: st_d.rdata = st_q.gsta; // RULE7
            A_GCON: st_d.rdata = st_q.gcon;
            A_GIE: st_d.rdata = st_q.gie;
            A_PAGE: st_d.rdata = st_q.page;
            A_IE1: st_d.rdata = st_q.ie1;
            A_IE2: st_d.rdata = st_q.ie2;
            A_EN1: st_d.rdata = {1'b0, st_q.armed[14:8]};
            A_EN2: st_d.rdata = st_q.armed[7:0];
            A_STCH: st_d.rdata = sel_ok ? st_q.stat[sel] : RST_BYTE;
            A_CONCH: st_d.rdata = sel_ok ? st_q.ctrl[sel] : RST_BYTE;
            default: begin
                st_d.rdata = RST_BYTE;
                for (int i = 0; i < 4; i++) begin
                    if (sfr_addr == A_IDT1 + 8'(i)) begin
                        st_d.rdata = st_q.idt[i];
                    end
                    if (sfr_addr == A_IDM1 + 8'(i)) begin
                        st_d.rdata = st_q.idm[i];
                    end
                end
            end
        endcase
        if (!sfr_rd) begin
            st_d.rdata = st_q.rdata;
        end

        // Enable takes effect after a settle time; disable counts its settle time only on an idle bus
        case (st_q.en_st)
            EN_OFF: begin
                st_d.en_cnt = '0;
                if (req) begin
                    st_d.en_st = EN_GOING_ON;
                end
            end
            EN_GOING_ON: begin
                st_d.en_cnt = st_q.en_cnt + 16'h0001;
                if (!req) begin
                    st_d.en_st = EN_OFF;
                end else if (st_q.en_cnt == 16'(ENA_DELAY - 1)) begin
                    st_d.en_st = EN_ON; // RULE4
                end
            end
            EN_ON: begin
                st_d.en_cnt = '0;
                if (!req) begin
                    st_d.en_st = EN_GOING_OFF;
                end
            end
            EN_GOING_OFF: begin
                if (idle) begin
                    st_d.en_cnt = st_q.en_cnt + 16'h0001;
                end
                if (req) begin
                    st_d.en_st = EN_ON;
                end else if (idle && st_q.en_cnt == 16'(ENA_DELAY - 1)) begin
                    st_d.en_st = EN_OFF; // RULE4
                end
            end
            default: st_d.en_st = EN_OFF;
        endcase

        // Snapshot of engine state; reserved bits read as zero
        st_d.gsta = RST_BYTE; // RULE6
        st_d.gsta[GS_OVL] = eng_ovl_own; // RULE1
        st_d.gsta[GS_TRANSMIT_BUSY] = eng_tx_frame || eng_tx_ack
            || (eng_ifs && eng_tx_pending); // RULE2
        st_d.gsta[GS_RECEIVE_BUSY] = eng_rx_active; // RULE3
        st_d.gsta[GS_ENF] = (st_q.en_st == EN_ON)
            || (st_q.en_st == EN_GOING_OFF); // RULE4
        st_d.gsta[GS_BUS_OFF_STATE] = eng_bus_off;
        st_d.gsta[GS_ERROR_PASSIVE_STATE] = eng_err_passive;

        st_d.accept = (((eng_rx_id ^ std_id) & std_mask) == 11'h000); // RULE11
    end

    // Registered snapshot keeps a read stable across engine changes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d; // RULE21
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // No interrupt output exists: the status bits are for polling
    assign can_enable = st_q.gsta[GS_ENF]; // RULE5
    assign sfr_rdata = st_q.rdata;
    assign obj_armed = st_q.armed;
    assign tx_launch = st_q.launch;
    assign tx_launch_obj = st_q.launch_obj;
    assign id_accept = st_q.accept;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_ovl_flag_follows: assert property ( // RULE1
        eng_ovl_own |=> st_q.gsta[GS_OVL])
        else $error("overload bit missed own overload frame");

    a_tx_busy_ifs: assert property ( // RULE2
        (eng_ifs && eng_tx_pending && !eng_tx_frame) |=> st_q.gsta[GS_TRANSMIT_BUSY])
        else $error("transmit busy low while a frame waits");

    a_rx_busy_on: assert property ( // RULE3
        eng_rx_active[*2] |=>
        st_q.gsta[GS_RECEIVE_BUSY] && $past(st_q.gsta[GS_RECEIVE_BUSY]))
        else $error("receive busy low during receive");

    a_enable_delay_on: assert property ( // RULE4
        $rose(st_q.en_st == EN_ON) |->
        $past(st_q.en_cnt) == 16'(ENA_DELAY - 1)
        || $past(st_q.en_st) == EN_GOING_OFF)
        else $error("enable took effect without its delay");

    a_reserved_zero: assert property ( // RULE6
        !st_q.gsta[7] && !st_q.gsta[5])
        else $error("reserved status bit set");

    a_gsta_read_back: assert property ( // RULE7
        (sfr_rd && sfr_addr == A_GSTA) |=> sfr_rdata == $past(st_q.gsta))
        else $error("global status read returned wrong value");

    a_msg_ptr_wrap: assert property ( // RULE18
        (sfr_rd && sfr_addr == A_MSG) |=>
        st_q.page[2:0] == $past(st_q.page[2:0]) + 3'h1)
        else $error("message pointer did not advance");

    a_done_disarms: assert property ( // RULE19
        (eng_done && eng_done_obj < 4'(NUM_OBJ)
        && !(sfr_wr && sfr_addr == A_CONCH)) |=>
        !obj_armed[$past(eng_done_obj)])
        else $error("object stayed armed after completion");

    a_rx_arm: assert property ( // RULE12
        (sfr_wr && sfr_addr == A_CONCH && sfr_wdata == 8'h88 && sel_ok) |=>
        obj_armed[$past(sel)] && !tx_launch)
        else $error("receive arm write failed");

    a_tx_launch: assert property ( // RULE13
        (sfr_wr && sfr_addr == A_CONCH && sfr_wdata == 8'h18 && sel_ok) |=>
        tx_launch && tx_launch_obj == $past(sel) ##1 !tx_launch)
        else $error("transmit launch pulse wrong");

endmodule : cgs_top
`default_nettype wire

// file: rtl/cgs_pkg.sv
package cgs_pkg;

    // ------------------------------------------------------------
    // Special-function addresses
    // ------------------------------------------------------------
    localparam logic [7:0] A_GSTA = 8'haa;
    localparam logic [7:0] A_GCON = 8'hab;
    localparam logic [7:0] A_GIE = 8'hac;
    localparam logic [7:0] A_PAGE = 8'hb1;
    localparam logic [7:0] A_STCH = 8'hb2;
    localparam logic [7:0] A_CONCH = 8'hb3;
    localparam logic [7:0] A_MSG = 8'ha3;
    localparam logic [7:0] A_IE1 = 8'hc2;
    localparam logic [7:0] A_IE2 = 8'hc3;
    localparam logic [7:0] A_EN1 = 8'hce;
    localparam logic [7:0] A_EN2 = 8'hcf;
    localparam logic [7:0] A_IDT1 = 8'hbc;
    localparam logic [7:0] A_IDM1 = 8'hb4;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int GS_OVL = 6;
    localparam int GS_TRANSMIT_BUSY = 4;
    localparam int GS_RECEIVE_BUSY = 3;
    localparam int GS_ENF = 2;
    localparam int GS_BUS_OFF_STATE = 1;
    localparam int GS_ERROR_PASSIVE_STATE = 0;
    localparam int GC_ENA = 1;
    localparam int CT_CFG_LSB = 6;
    localparam int CT_TXREQ = 4;
    localparam int PG_OBJ_LSB = 4;
    localparam int PTR_W = 3;
    localparam int NUM_OBJ = 15;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Timing and buffering
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int ENA_DELAY_NS = 1100;
    localparam int ENA_CYC = (ENA_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = 4 + PTR_W + 8;

    typedef enum logic [1:0] {
        CFG_DIS = 2'b00,
        CFG_TX = 2'b01,
        CFG_RX = 2'b10,
        CFG_RXBUF = 2'b11
    } cgs_cfg_t;

    typedef enum logic [1:0] {
        EN_OFF = 2'b00,
        EN_GOING_ON = 2'b01,
        EN_ON = 2'b11,
        EN_GOING_OFF = 2'b10
    } cgs_en_t;

endpackage : cgs_pkg

// file: rtl/cgs_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cgs_fifo_if #(parameter int W = 15);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, input in_data, input out_ready,
        output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
        input in_ready, input out_valid, input out_data);
endinterface : cgs_fifo_if
`default_nettype wire

// file: rtl/cgs_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module cgs_fifo #(
    parameter int W = 15,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    cgs_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } cgs_fifo_st_t;

    cgs_fifo_st_t st_q;
    cgs_fifo_st_t st_d;
    logic full;
    logic empty;

    // ------------------------------------------------------------
    // Flags from pointer compare
    // ------------------------------------------------------------
    assign empty = (st_q.wp == st_q.rp);
    assign full = (st_q.wp[AW] != st_q.rp[AW])
        && (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]);
    assign f.in_ready = !full;
    assign f.out_valid = !empty;
    // Head word is read straight from the storage flops
    assign f.out_data = st_q.mem[st_q.rp[AW-1:0]];

    always_comb begin
        st_d = st_q;
        if (f.in_valid && !full) begin
            st_d.mem[st_q.wp[AW-1:0]] = f.in_data;
            st_d.wp = st_q.wp + 1'b1;
        end
        if (f.out_ready && !empty) begin
            st_d.rp = st_q.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    a_fifo_no_overfill: assert property (@(posedge clk) disable iff (rst)
        (st_q.wp - st_q.rp) <= (AW+1)'(DEPTH)) // RULE14
        else $error("fifo holds more words than its depth");

endmodule : cgs_fifo
`default_nettype wire

// file: verif/cgs_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Frame engine and bus side stand-in
// ------------------------------------------------------------
module cgs_engine_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic [7:0] cmd,
    input wire logic msg_valid,
    input wire logic [3:0] msg_obj,
    input wire logic [2:0] msg_ptr,
    input wire logic [7:0] msg_byte,
    output logic msg_ready,
    output logic [7:0] lvl
);
    logic [14:0] seen [$];
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            msg_ready <= 1'b0;
            lvl <= 8'h00;
        end else begin
            // Levels lag the command a cycle, as a real engine would
            lvl <= cmd;
            // Stall lets the buffer fill up behind a slow bus
            msg_ready <= !stall;
            if (msg_valid && msg_ready) begin
                seen.push_back({msg_obj, msg_ptr, msg_byte});
            end
        end
    end
endmodule : cgs_engine_model
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cgs_pkg::*;
    localparam int DLY = 2;
    logic clk, rst, sfr_wr, sfr_rd, msg_wr_ready, eng_done, can_enable;
    logic tx_launch, id_accept, msg_valid, msg_ready, stall;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, msg_byte, cmd, lvl, r;
    logic [3:0] eng_done_obj, tx_launch_obj, msg_obj;
    logic [2:0] msg_ptr;
    logic [10:0] eng_rx_id;
    logic [14:0] obj_armed;
    int fail_count = 0;
    int comparisons = 0;

    cgs_top #(.ENA_DELAY(DLY)) cgs_top_inst (.clk(clk), .rst(rst),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .msg_wr_ready(msg_wr_ready),
        .eng_ovl_own(lvl[0]), .eng_tx_frame(lvl[1]), .eng_tx_ack(lvl[2]),
        .eng_ifs(lvl[3]), .eng_tx_pending(lvl[4]), .eng_rx_active(lvl[5]),
        .eng_bus_off(lvl[6]), .eng_err_passive(lvl[7]),
        .eng_done(eng_done), .eng_done_obj(eng_done_obj),
        .eng_rx_id(eng_rx_id), .can_enable(can_enable),
        .obj_armed(obj_armed), .tx_launch(tx_launch),
        .tx_launch_obj(tx_launch_obj), .id_accept(id_accept),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_obj(msg_obj),
        .msg_ptr(msg_ptr), .msg_byte(msg_byte));

    cgs_engine_model cgs_engine_model_inst (.clk(clk), .rst(rst),
        .stall(stall), .cmd(cmd), .msg_valid(msg_valid), .msg_obj(msg_obj),
        .msg_ptr(msg_ptr), .msg_byte(msg_byte), .msg_ready(msg_ready),
        .lvl(lvl));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(posedge clk);
        #1;
        d = sfr_rdata;
    endtask : rd

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_enable(input logic on);
        wr(A_GCON, on ? 8'h02 : 8'h00);
        chk("enable early", 16'(!on), 16'(can_enable));
        repeat (DLY + 3) @(posedge clk);
        #1;
        chk("enable late", 16'(on), 16'(can_enable));
        rd(A_GSTA, r);
        chk("status enabled", 16'(on ? 8'h04 : 8'h00), 16'(r));
        $display("t_enable done");
    endtask : t_enable

    task automatic t_status();
        logic [7:0] c [9] = '{8'h01, 8'h02, 8'h04, 8'h18, 8'h08, 8'h20,
            8'h40, 8'h80, 8'h00};
        logic [7:0] m [9] = '{8'h40, 8'h10, 8'h10, 8'h10, 8'h10, 8'h08,
            8'h02, 8'h01, 8'hff};
        logic [7:0] e [9] = '{8'h40, 8'h10, 8'h10, 8'h10, 8'h00, 8'h08,
            8'h02, 8'h01, 8'h04};
        for (int i = 0; i < 9; i++) begin
            cmd <= c[i];
            repeat (3) @(posedge clk);
            rd(A_GSTA, r);
            chk("status bit", 16'(e[i]), 16'(r & m[i]));
        end
        wr(A_GSTA, 8'h5b);
        rd(A_GSTA, r);
        chk("status ro", 16'h0004, 16'(r));
        rd(8'h00, r);
        chk("unmapped", 16'h0000, 16'(r));
        $display("t_status done");
    endtask : t_status

    task automatic t_rx();
        wr(A_PAGE, 8'h30);
        wr(A_IE2, 8'h08);
        wr(A_GIE, 8'h20);
        rd(A_IE2, r);
        chk("object irq enable", 16'h0008, 16'(r));
        rd(A_GIE, r);
        chk("general irq enable", 16'h0020, 16'(r));
        wr(A_STCH, 8'h00);
        wr(A_CONCH, 8'h00);
        wr(A_IDT1, 8'h20);
        wr(A_IDT1 + 8'h01, 8'h00);
        for (int i = 0; i < 4; i++) wr(A_IDM1 + 8'(i), 8'hff);
        wr(A_CONCH, 8'h88);
        chk("rx armed", 16'h0001, 16'(obj_armed[3]));
        @(posedge clk);
        eng_rx_id <= 11'h100;
        repeat (2) @(posedge clk);
        #1;
        chk("accept 100", 16'h0001, 16'(id_accept));
        @(posedge clk);
        eng_rx_id <= 11'h101;
        repeat (2) @(posedge clk);
        #1;
        chk("reject 101", 16'h0000, 16'(id_accept));
        @(posedge clk);
        eng_rx_id <= 11'h200;
        repeat (2) @(posedge clk);
        #1;
        chk("reject 200", 16'h0000, 16'(id_accept));
        rd(A_EN2, r);
        chk("overview", 16'h0008, 16'(r & 8'h08));
        @(posedge clk);
        eng_done <= 1'b1;
        eng_done_obj <= 4'h3;
        @(posedge clk);
        eng_done <= 1'b0;
        @(posedge clk);
        #1;
        chk("done clears", 16'h0000, 16'(obj_armed[3]));
        $display("t_rx done");
    endtask : t_rx

    task automatic t_tx();
        wr(A_PAGE, 8'hc0);
        wr(A_IE1, 8'h01);
        wr(A_STCH, 8'h00);
        wr(A_IDT1, 8'haa);
        wr(A_IDT1 + 8'h01, 8'ha0);
        rd(A_IE1, r);
        chk("object irq enable", 16'h0001, 16'(r));
        // Mask still all ones from the receive setup
        @(posedge clk);
        eng_rx_id <= 11'h555;
        repeat (2) @(posedge clk);
        #1;
        chk("accept 555", 16'h0001, 16'(id_accept));
        stall <= 1'b1;
        for (int i = 0; i < 16; i++) wr(A_MSG, 8'(i % 8));
        chk("buffer full", 16'h0000, 16'(msg_wr_ready));
        chk("head valid", 16'h0001, 16'(msg_valid));
        wr(A_MSG, 8'h99);
        stall <= 1'b0;
        repeat (40) @(posedge clk);
        #1;
        chk("drained", 16'h0000, 16'(msg_valid));
        chk("popped", 16'd16, 16'(cgs_engine_model_inst.seen.size()));
        foreach (cgs_engine_model_inst.seen[i])
            chk("obj ptr byte", 16'({4'hc, 3'(i), 8'(i % 8)}),
                16'(cgs_engine_model_inst.seen[i]));
        // Sixteen accepted bytes bring the pointer round to zero
        rd(A_MSG, r);
        chk("message read", 16'h0000, 16'(r));
        rd(A_PAGE, r);
        chk("pointer wrap", 16'h00c1, 16'(r));
        wr(A_CONCH, 8'h18);
        chk("launch", 16'h001c, 16'({tx_launch, tx_launch_obj}));
        $display("t_tx done");
    endtask : t_tx

    task automatic t_cfg();
        wr(A_PAGE, 8'h50);
        for (int c = 0; c < 4; c++) begin
            wr(A_CONCH, 8'(c << 6));
            chk("cfg launch", 16'(c == 1), 16'(tx_launch));
            chk("cfg armed", 16'(c != 0), 16'(obj_armed[5]));
        end
        $display("t_cfg done");
    endtask : t_cfg

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (6000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        stall = 1'b0;
        cmd = 8'h00;
        eng_done = 1'b0;
        eng_done_obj = 4'h0;
        eng_rx_id = 11'h000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_enable(1'b1);
        t_status();
        t_rx();
        t_tx();
        t_cfg();
        t_enable(1'b0);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
